// ---- design/tbp_pkg.sv ----
// Package for the buffered PWM timer: register map, field positions,
// reset values, codes and the packed types shared by the design.
// Assumes an APB slave with byte addresses on an 8-bit address.
package tbp_pkg;

    // Bus word and address types
    typedef logic [31:0] tbp_word_t;
    typedef logic [7:0]  tbp_addr_t;

    // Register byte addresses, one aligned word each
    localparam tbp_addr_t TBP_ADDR_TSC     = 8'h00;
    localparam tbp_addr_t TBP_ADDR_CNT_HI  = 8'h04;
    localparam tbp_addr_t TBP_ADDR_CNT_LO  = 8'h08;
    localparam tbp_addr_t TBP_ADDR_MOD_HI  = 8'h0C;
    localparam tbp_addr_t TBP_ADDR_MOD_LO  = 8'h10;
    localparam tbp_addr_t TBP_ADDR_CH0_SC  = 8'h14;
    localparam tbp_addr_t TBP_ADDR_CH0_HI  = 8'h18;
    localparam tbp_addr_t TBP_ADDR_CH0_LO  = 8'h1C;
    localparam tbp_addr_t TBP_ADDR_CH1_SC  = 8'h20;
    localparam tbp_addr_t TBP_ADDR_CH1_HI  = 8'h24;
    localparam tbp_addr_t TBP_ADDR_CH1_LO  = 8'h28;

    // Field positions in timer_status_control
    localparam int TBP_TSC_FLAG  = 7;
    localparam int TBP_TSC_IRQEN = 6;
    localparam int TBP_TSC_HALT  = 5;
    localparam int TBP_TSC_CLEAR = 4;

    // Reset values
    localparam logic [15:0] TBP_MOD_RESET  = 16'hFFFF;
    localparam logic [2:0]  TBP_CDS_RESET  = 3'h0;
    localparam logic [1:0]  TBP_HALT_RESET = 2'h1;

    // Clock divider code that selects the external clock pin
    localparam logic [2:0] TBP_CDS_EXT = 3'h7;

    // Edge/level codes
    localparam logic [1:0] TBP_EL_PORT   = 2'h0;
    localparam logic [1:0] TBP_EL_TOGGLE = 2'h1;
    localparam logic [1:0] TBP_EL_CLEAR  = 2'h2;
    localparam logic [1:0] TBP_EL_SET    = 2'h3;

    // Channel status/control layout, bit 7 down to bit 0
    typedef struct packed {
        logic event_flag;      // Capture or compare occurred
        logic irq_enable;      // Channel interrupt enable
        logic buffer_select;   // Buffer link, channel 0 only
        logic mode_select;     // Compare when set, capture when clear
        logic edge_level_hi;   // Edge/level high bit
        logic edge_level_lo;   // Edge/level low bit
        logic overflow_toggle; // Toggle output on overflow
        logic full_duty_force; // Force 100% duty with toggle off
    } tbp_chan_ctrl_t;

    localparam tbp_chan_ctrl_t TBP_CHAN_RESET = 8'h00;

endpackage : tbp_pkg

// ---- design/tbp_timer.sv ----
// 16-bit two-channel timer with buffered PWM, reached over APB.
// Assumes pins arrive asynchronous to pclk; wait, stop and break levels
// come from system logic on pclk.
//
// Functional notes
// - Link bit merges channels into buffered PWM
// - Last written value pair governs after overflow
// - Linked: channel 1 control unused, pin released
// - Link bit outranks channel mode bit
// - Overflow toggle off gives 0% duty
// - Full duty force with toggle off gives 100%
// - Rollover sets overflow flag, enable requests interrupt
// - Channel events set flag, enable gates request
// - Wait mode: runs, registers closed, wakes CPU
// - Stop mode freezes counter and keeps registers
// - Break halts counter and blocks captures
// - Break clears only with clear-allow set
// - Without clear-allow, break preserves flags and steps
// - Code 111 counts external clock pin
// - External clock pin forced to input with code 111
// - Each pin capture or compare, buffering allowed
// - Overflow flag clears by read then write 0
// - Halt bit stops counting, set at reset
// - Clear bit zeroes counter and prescaler, reads 0
// - Divider codes select bus clock divide 1..64
// - Modulo wrap; high byte write mutes overflow
// - High byte read latches low byte
// - Mode and edge/level decode per channel
`timescale 1ns/100ps
module tbp_timer (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire tbp_pkg::tbp_addr_t paddr,
    input  wire tbp_pkg::tbp_word_t pwdata,
    output tbp_pkg::tbp_word_t     prdata,
    output logic                   pready,
    output logic                   pslverr,
    // System state
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    input  wire logic              break_active,
    input  wire logic              break_clear_allow,
    // Pins
    input  wire logic              ext_count_clock_pin,
    output logic                   ext_pin_force_input,
    input  wire logic [1:0]        chan_pin_in,
    output logic [1:0]             chan_pin_out,
    output logic [1:0]             chan_pin_oe,
    // Requests
    output logic                   overflow_irq,
    output logic [1:0]             chan_irq,
    output logic                   wake_req
);
    import tbp_pkg::*;

    // Mask of prescaler bits that must be all ones for one tick
    function automatic logic [6:0] div_mask(input logic [2:0] code);
        div_mask = 7'((8'h01 << code) - 8'h01);
    endfunction : div_mask

    // Address decode for mapped words
    function automatic logic addr_mapped(input tbp_addr_t a);
        addr_mapped = (a <= TBP_ADDR_CH1_LO) && (a[1:0] == 2'h0);
    endfunction : addr_mapped

    // Control and status state
    logic           irq_en_q;        // Overflow interrupt enable
    logic           halt_q;          // Counter halt
    logic [2:0]     cds_q;           // Clock divider select
    logic [6:0]     pre_q;           // Prescaler
    logic [15:0]    cnt_q;           // Counter
    logic [15:0]    mod_q;           // Modulo value
    logic           mod_pend_q;      // High byte written, low pending
    logic [7:0]     cnt_lo_buf_q;    // Latched counter low byte
    logic           cnt_latched_q;   // Low byte buffer valid
    tbp_chan_ctrl_t chc_q [2];       // Channel control bits
    logic [15:0]    chv_q [2];       // Channel value registers
    logic           last_wr_q;       // Last written value pair
    logic           act_sel_q;       // Value pair in control
    logic [1:0]     out_q;           // Channel output levels
    logic [2:0]     flag_q;          // Flags: ovf, ch0, ch1
    logic [2:0]     arm_q;           // First clear step done
    // Synchronisers
    logic           ext_s1_q, ext_s2_q, ext_s3_q;
    logic [1:0]     pin_s1_q, pin_s2_q, pin_s3_q;

    // Decoded bus and datapath terms
    logic           acc, wr, rd, setup, brk_ok, buffered, run, tick, adv, wrap, ovf_evt, clr_wr;
    logic [1:0]     el [2];
    logic [1:0]     out_mode, cap_mode, cmp_evt, cap_evt;
    logic [15:0]    cv [2];
    logic [2:0]     set_evt, rd_arm;
    tbp_word_t      rdata;

    // Bus phases; registers closed to the CPU in wait mode
    assign setup   = psel & ~penable;
    assign acc     = psel & penable & addr_mapped(paddr) & ~wait_mode;
    assign wr      = acc & pwrite;
    assign rd      = acc & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~addr_mapped(paddr) | wait_mode);
    // Status may change in break only with clear-allow
    assign brk_ok  = ~break_active | break_clear_allow;
    assign clr_wr  = wr & (paddr == TBP_ADDR_TSC) & pwdata[TBP_TSC_CLEAR];

    // Link bit overrides channel mode
    assign buffered = chc_q[0].buffer_select;
    assign el[0]    = {chc_q[0].edge_level_hi, chc_q[0].edge_level_lo};
    assign el[1]    = {chc_q[1].edge_level_hi, chc_q[1].edge_level_lo};

    // Mode decode per channel
    always_comb begin
        out_mode[0] = (buffered | chc_q[0].mode_select) & (el[0] != TBP_EL_PORT);
        cap_mode[0] = ~buffered & ~chc_q[0].mode_select & (el[0] != TBP_EL_PORT);
        out_mode[1] = ~buffered & chc_q[1].mode_select & (el[1] != TBP_EL_PORT);
        cap_mode[1] = ~buffered & ~chc_q[1].mode_select & (el[1] != TBP_EL_PORT);
    end

    // Counter runs unless halted, stopped or in break
    assign run  = ~halt_q & ~stop_mode & ~break_active;
    assign tick = (cds_q == TBP_CDS_EXT) ? (ext_s2_q & ~ext_s3_q)
                                         : ((pre_q & div_mask(cds_q)) == div_mask(cds_q));
    assign adv  = tick & run & ~clr_wr;
    assign wrap = adv & (cnt_q == mod_q);
    assign ovf_evt = wrap & ~mod_pend_q;

    // Compare values; channel 0 follows the active pair when linked
    assign cv[0] = (buffered & act_sel_q) ? chv_q[1] : chv_q[0];
    assign cv[1] = chv_q[1];

    // Compare and capture events per channel
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_evt[i] = out_mode[i] & adv & (cnt_q == cv[i]);
            cap_evt[i] = cap_mode[i] & run & (
                         (el[i][0] & pin_s2_q[i] & ~pin_s3_q[i]) |
                         (el[i][1] & ~pin_s2_q[i] & pin_s3_q[i]));
        end
    end
    assign set_evt = {cmp_evt[1] | cap_evt[1], cmp_evt[0] | cap_evt[0], ovf_evt};

    // Read mux, sampled in the setup phase
    always_comb begin
        rdata = '0;
        unique case (paddr)
            TBP_ADDR_TSC:    rdata[7:0] = {flag_q[0], irq_en_q, halt_q, 1'b0, 1'b0, cds_q};
            TBP_ADDR_CNT_HI: rdata[7:0] = cnt_q[15:8];
            TBP_ADDR_CNT_LO: rdata[7:0] = cnt_latched_q ? cnt_lo_buf_q : cnt_q[7:0];
            TBP_ADDR_MOD_HI: rdata[7:0] = mod_q[15:8];
            TBP_ADDR_MOD_LO: rdata[7:0] = mod_q[7:0];
            TBP_ADDR_CH0_SC: rdata[7:0] = {flag_q[1], 7'(chc_q[0])};
            TBP_ADDR_CH0_HI: rdata[7:0] = chv_q[0][15:8];
            TBP_ADDR_CH0_LO: rdata[7:0] = chv_q[0][7:0];
            TBP_ADDR_CH1_SC: rdata[7:0] = buffered ? 8'h00 : {flag_q[2], 7'(chc_q[1])};
            TBP_ADDR_CH1_HI: rdata[7:0] = chv_q[1][15:8];
            TBP_ADDR_CH1_LO: rdata[7:0] = chv_q[1][7:0];
            default:         rdata = '0;
        endcase
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= rdata;
        end
    end

    // Timer status/control bits; halt is set by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 1'b0;
            halt_q   <= TBP_HALT_RESET[0];
            cds_q    <= TBP_CDS_RESET;
        end else if (wr && paddr == TBP_ADDR_TSC) begin
            irq_en_q <= pwdata[TBP_TSC_IRQEN];
            halt_q   <= pwdata[TBP_TSC_HALT];
            cds_q    <= pwdata[2:0];
        end
    end

    // Prescaler, zeroed by the clear bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (clr_wr) begin
            pre_q <= '0;
        end else if (run) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // Counter with modulo wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clr_wr) begin
            cnt_q <= '0;
        end else if (wrap) begin
            cnt_q <= '0;
        end else if (adv) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Modulo registers; high byte write mutes overflow until low byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_q      <= TBP_MOD_RESET;
            mod_pend_q <= 1'b0;
        end else if (wr && paddr == TBP_ADDR_MOD_HI) begin
            mod_q[15:8] <= pwdata[7:0];
            mod_pend_q  <= 1'b1;
        end else if (wr && paddr == TBP_ADDR_MOD_LO) begin
            mod_q[7:0]  <= pwdata[7:0];
            mod_pend_q  <= 1'b0;
        end
    end

    // Counter low byte latch on high byte read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_lo_buf_q  <= '0;
            cnt_latched_q <= 1'b0;
        end else if (rd && paddr == TBP_ADDR_CNT_HI && !cnt_latched_q) begin
            cnt_lo_buf_q  <= cnt_q[7:0];
            cnt_latched_q <= 1'b1;
        end else if (rd && paddr == TBP_ADDR_CNT_LO) begin
            cnt_latched_q <= 1'b0;
        end
    end

    // Channel control bits; channel 1 ignored while linked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chc_q[0] <= TBP_CHAN_RESET;
            chc_q[1] <= TBP_CHAN_RESET;
        end else begin
            if (wr && paddr == TBP_ADDR_CH0_SC) begin
                chc_q[0] <= {1'b0, pwdata[6:0]};
            end
            if (wr && paddr == TBP_ADDR_CH1_SC && !buffered) begin
                chc_q[1] <= {1'b0, pwdata[6], 1'b0, pwdata[4:0]};
            end
        end
    end

    // Channel value registers, loaded by writes or captures
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chv_q[0] <= '0;
            chv_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_evt[i]) begin
                    chv_q[i] <= cnt_q;
                end else if (wr && paddr == (i == 0 ? TBP_ADDR_CH0_HI : TBP_ADDR_CH1_HI)) begin
                    chv_q[i][15:8] <= pwdata[7:0];
                end else if (wr && paddr == (i == 0 ? TBP_ADDR_CH0_LO : TBP_ADDR_CH1_LO)) begin
                    chv_q[i][7:0] <= pwdata[7:0];
                end
            end
        end
    end

    // Buffered pair tracking: last written pair takes over at wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_wr_q <= 1'b0;
            act_sel_q <= 1'b0;
        end else begin
            if (wr && (paddr == TBP_ADDR_CH0_HI || paddr == TBP_ADDR_CH0_LO)) begin
                last_wr_q <= 1'b0;
            end else if (wr && (paddr == TBP_ADDR_CH1_HI || paddr == TBP_ADDR_CH1_LO)) begin
                last_wr_q <= 1'b1;
            end
            if (!buffered) begin
                act_sel_q <= 1'b0;
            end else if (wrap) begin
                act_sel_q <= last_wr_q;
            end
        end
    end

    // Channel output levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (el[i] == TBP_EL_PORT) begin
                    out_q[i] <= ~chc_q[i].mode_select;
                end else if (cmp_evt[i]) begin
                    unique case (el[i])
                        TBP_EL_TOGGLE: out_q[i] <= ~out_q[i];
                        TBP_EL_CLEAR:  out_q[i] <= 1'b0;
                        TBP_EL_SET:    out_q[i] <= 1'b1;
                        default:       out_q[i] <= out_q[i];
                    endcase
                end else if (out_mode[i] && wrap && chc_q[i].overflow_toggle) begin
                    out_q[i] <= ~out_q[i];
                end
            end
        end
    end

    // Pin drive; full duty force with overflow toggle off holds the output high
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_pin_oe[i]  = out_mode[i];
            chan_pin_out[i] = out_mode[i] &
                              (out_q[i] | (chc_q[i].full_duty_force & ~chc_q[i].overflow_toggle));
        end
    end
    assign ext_pin_force_input = (cds_q == TBP_CDS_EXT);

    // Arm mask: reading a register with its flag set, outside protected break
    assign rd_arm = {rd && paddr == TBP_ADDR_CH1_SC && !buffered,
                     rd && paddr == TBP_ADDR_CH0_SC,
                     rd && paddr == TBP_ADDR_TSC} & {3{brk_ok}};

    // Flags with two-step clear; a new event wins and cancels the arm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
            arm_q  <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (set_evt[i]) begin
                    flag_q[i] <= 1'b1;
                    arm_q[i]  <= 1'b0;
                end else if (rd_arm[i] && flag_q[i]) begin
                    arm_q[i]  <= 1'b1;
                end else if (wr && brk_ok && arm_q[i] && !pwdata[7] &&
                             paddr == (i == 0 ? TBP_ADDR_TSC : (i == 1 ? TBP_ADDR_CH0_SC : TBP_ADDR_CH1_SC))) begin
                    flag_q[i] <= 1'b0;
                    arm_q[i]  <= 1'b0;
                end
            end
        end
    end

    // Interrupt requests and wake from wait
    assign overflow_irq = flag_q[0] & irq_en_q;
    assign chan_irq[0]  = flag_q[1] & chc_q[0].irq_enable;
    assign chan_irq[1]  = flag_q[2] & chc_q[1].irq_enable & ~buffered;
    assign wake_req     = wait_mode & (overflow_irq | (|chan_irq));

    // Two-flop synchronisers plus edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            ext_s1_q <= ext_count_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            pin_s1_q <= chan_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

endmodule : tbp_timer

// ---- tb/tbp_timer_checker.sv ----
// Port-level checker for the buffered PWM timer.
// Assumes it is bound to tbp_timer and sees only its ports.
`timescale 1ns/100ps
module tbp_timer_checker (
    // APB slave
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire tbp_pkg::tbp_addr_t paddr,
    input wire tbp_pkg::tbp_word_t pwdata,
    input wire tbp_pkg::tbp_word_t prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // System state
    input wire logic               wait_mode,
    input wire logic               stop_mode,
    input wire logic               break_active,
    input wire logic               break_clear_allow,
    // Pins
    input wire logic               ext_count_clock_pin,
    input wire logic               ext_pin_force_input,
    input wire logic [1:0]         chan_pin_in,
    input wire logic [1:0]         chan_pin_out,
    input wire logic [1:0]         chan_pin_oe,
    // Requests
    input wire logic               overflow_irq,
    input wire logic [1:0]         chan_irq,
    input wire logic               wake_req
);
    import tbp_pkg::*;
    logic wr; // Write access phase this cycle, whether taken or refused
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_WAIT_REFUSE: assert property (psel && penable && wait_mode |-> pslverr)
        else $error("access during wait mode was not refused");
    AST_WAKE: assert property (wake_req == (wait_mode && (overflow_irq || (|chan_irq))))
        else $error("wake request does not follow enabled requests");
    AST_EXT_SET: assert property ($past(wr && paddr == TBP_ADDR_TSC && !wait_mode) |->
        ext_pin_force_input == ($past(pwdata[2:0]) == TBP_CDS_EXT)) else $error("pin direction not per divider code");
    AST_EXT_STABLE: assert property (!$past(wr) |-> $stable(ext_pin_force_input))
        else $error("pin direction moved without a write");
    AST_STOP_HOLD: assert property ($past(stop_mode) && !$past(wr) |-> $stable(overflow_irq))
        else $error("overflow request moved in stop mode");
    AST_BREAK_NO_OVF: assert property ($past(break_active) && !$past(wr) |-> !$rose(overflow_irq))
        else $error("overflow raised while halted by break");
    AST_OVF_FALL: assert property ($fell(overflow_irq) |-> $past(wr))
        else $error("overflow request dropped without a write");
    AST_CHAN_FALL: assert property ($fell(chan_irq[0]) |-> $past(wr))
        else $error("channel request dropped without a write");
    // Main scenarios reached
    COV_OVF: cover property (overflow_irq);
    COV_EXT: cover property (ext_pin_force_input);
    COV_WAIT: cover property (pslverr && wait_mode);
endmodule : tbp_timer_checker

bind tbp_timer tbp_timer_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wait_mode, .stop_mode, .break_active, .break_clear_allow, .ext_count_clock_pin,
    .ext_pin_force_input, .chan_pin_in, .chan_pin_out, .chan_pin_oe, .overflow_irq, .chan_irq, .wake_req);

// ---- tb/tb_top.sv ----
// Self-checking bench for the buffered PWM timer over APB.
// Assumes the register map and timing of the designer's hand-over.
`timescale 1ns/100ps
module tb_top;
    import tbp_pkg::*;
    logic       pclk, presetn, psel, penable, pwrite, wait_mode, stop_mode;
    logic       break_active, break_clear_allow, ext_count_clock_pin, pready, pslverr;
    logic       ext_pin_force_input, overflow_irq, wake_req, err;
    tbp_addr_t  paddr;
    tbp_word_t  pwdata, prdata, rd;
    logic [1:0] chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq;
    logic [31:0] rng;
    int         errors, n_tests, m, k;
    tbp_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wait_mode, .stop_mode, .break_active, .break_clear_allow, .ext_count_clock_pin, .ext_pin_force_input,
        .chan_pin_in, .chan_pin_out, .chan_pin_oe, .overflow_irq, .chan_irq, .wake_req);
    // Fixed-seed xorshift source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic summarize();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input tbp_addr_t a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 19) begin errors++; summarize(); end
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Wait for the overflow request under a bound
    task automatic wait_ovf();
        for (int i = 0; i <= 200; i++) begin
            @(posedge pclk);
            if (overflow_irq === 1'b1) break;
            if (i == 200) begin errors++; summarize(); end
        end
    endtask : wait_ovf
    // Clock source, 25 ns period
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Channel pin levels from the rng state and check count, driven every cycle
    always @(posedge pclk) chan_pin_in <= rng[1:0] ^ n_tests[1:0];
    initial begin
        {psel, penable, pwrite, wait_mode, stop_mode, break_active, break_clear_allow} = '0;
        {ext_count_clock_pin, chan_pin_in, paddr, pwdata, errors, n_tests} = '0;
        presetn = 1'b0; rng = 32'd59;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, TBP_ADDR_TSC, 0); check(rd, 32'h20);
        apb(0, TBP_ADDR_MOD_LO, 0); check(rd, 32'hFF);
        apb(0, 8'h2C, 0); check(err, 1);
        check(rd, 0);
        wait_mode <= 1'b1;
        apb(1, TBP_ADDR_TSC, 8'h07); check(err, 1);
        wait_mode <= 1'b0;
        apb(0, TBP_ADDR_TSC, 0); check(rd, 32'h20);
        // Setup order kept: modulo while halted from reset, then clear and run in one write
        rng = xs(rng); m = 3 + rng[2:0];
        apb(1, TBP_ADDR_MOD_HI, 0); apb(1, TBP_ADDR_MOD_LO, m[7:0]);
        apb(1, TBP_ADDR_TSC, 8'h50); wait_ovf(); check(overflow_irq, 1);
        apb(1, TBP_ADDR_TSC, 8'h60); apb(0, TBP_ADDR_TSC, 0); check(rd, 32'hE0);
        apb(1, TBP_ADDR_TSC, 8'hE0); apb(1, TBP_ADDR_TSC, 8'h70);
        @(posedge pclk); check(overflow_irq, 0);
        apb(0, TBP_ADDR_TSC, 0); check(rd, 32'h60);
        apb(0, TBP_ADDR_CNT_LO, 0); check(rd, 0);
        stop_mode <= 1'b1; apb(1, TBP_ADDR_TSC, 8'h40); repeat (20) @(posedge pclk);
        apb(0, TBP_ADDR_CNT_LO, 0); check(rd, 0);
        stop_mode <= 1'b0; wait_ovf();
        break_active <= 1'b1;
        apb(0, TBP_ADDR_TSC, 0); apb(1, TBP_ADDR_TSC, 8'h40); apb(0, TBP_ADDR_TSC, 0); check(rd[7], 1);
        apb(0, TBP_ADDR_CNT_LO, 0); k = rd; apb(0, TBP_ADDR_CNT_LO, 0); check(rd, k);
        break_clear_allow <= 1'b1;
        apb(0, TBP_ADDR_TSC, 0); apb(1, TBP_ADDR_TSC, 8'h40);
        {break_active, break_clear_allow} <= 2'b00;
        apb(0, TBP_ADDR_TSC, 0); check(rd[7], 0);
        apb(1, TBP_ADDR_TSC, 8'h17);
        @(posedge pclk); check(ext_pin_force_input, 1);
        rng = xs(rng); k = 1 + rng[1:0] % 3;
        for (int i = 0; i < 2 * k; i++) begin
            ext_count_clock_pin <= ~ext_count_clock_pin;
            repeat (6) @(posedge pclk);
        end
        apb(0, TBP_ADDR_CNT_LO, 0); check(rd, k);
        apb(1, TBP_ADDR_TSC, 8'h00);
        @(posedge pclk); check(ext_pin_force_input, 0);
        // Clear-on-compare only, never toggle-on-compare, for PWM
        apb(1, TBP_ADDR_CH0_LO, 8'h01); apb(1, TBP_ADDR_CH0_SC, 8'h19);
        repeat (3 * m + 3) begin @(posedge pclk); check({chan_pin_oe[0], chan_pin_out[0]}, 2'b11); end
        apb(1, TBP_ADDR_CH0_SC, 8'h18); repeat (2 * m + 2) @(posedge pclk);
        repeat (m + 1) begin @(posedge pclk); check(chan_pin_out[0], 0); end
        // Linked pair set up with no value write to the active pair
        apb(1, TBP_ADDR_CH0_SC, 8'h29); apb(1, TBP_ADDR_CH1_SC, 8'hFF);
        apb(0, TBP_ADDR_CH1_SC, 0); check(rd, 0);
        check({chan_pin_oe, chan_irq[1]}, 3'b010);
        summarize();
    end
endmodule : tb_top
